// File: rtl/spfc_core.sv
/*
 four counter units for semi-period, period and frequency capture, APB registers
 and a result FIFO streamed out. assumes gate, source, timebase and sample clock
 inputs are synchronous levels on pclk; the stream sink may stall.
*/
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "spfc_defines.svh"
module spfc_core (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic [`SPFC_ADDR_W-1:0]  paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`SPFC_CNT_W-1:0]   pwdata,
    output logic      [`SPFC_CNT_W-1:0]   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [`SPFC_NCH-1:0]     gate_in,
    input  wire logic [`SPFC_NCH-1:0]     source_in,
    input  wire logic [`SPFC_TB_N-1:0]    timebase_in,
    input  wire logic                     sample_clk,
    input  wire logic                     programmable_function_pin,
    output logic      [`SPFC_NCH-1:0]     pulse_out,
    output logic                          res_valid,
    input  wire logic                     res_ready,
    output spfc_pkg::spfc_ent_s           res_data
);
    spfc_pkg::spfc_state_s s;
    spfc_pkg::spfc_state_s n;
    logic [`SPFC_NCH-1:0]  geff;
    logic [`SPFC_NCH-1:0]  ge;
    logic [`SPFC_NCH-1:0]  se;
    logic [`SPFC_NCH-1:0]  ke;
    logic                  found;
    logic                  wr;
    logic                  acc_wr;

    function automatic spfc_pkg::spfc_chan_s spfc_put(input spfc_pkg::spfc_chan_s c,
                                                      input logic [`SPFC_CNT_W-1:0] v);
        spfc_put = c;
        unique case (c.pend_n)
            `SPFC_PEND_NONE: begin
                spfc_put.pend_a = v;
                spfc_put.pend_n = `SPFC_PEND_ONE;
            end
            `SPFC_PEND_ONE: begin
                spfc_put.pend_b = v;
                spfc_put.pend_n = `SPFC_PEND_TWO;
            end
            default: spfc_put.orun = 1'b1;
        endcase
    endfunction : spfc_put

    function automatic spfc_pkg::spfc_chan_s spfc_inc(input spfc_pkg::spfc_chan_s c);
        spfc_inc = c;
        if (&c.cnt)
            spfc_inc.ovf = 1'b1;
        spfc_inc.cnt = c.cnt + `SPFC_CNT_W'(1);
    endfunction : spfc_inc

    assign pready    = 1'b1;
    assign prdata    = s.prdata;
    assign res_valid = (s.lvl != '0);
    assign res_data  = s.mem[s.rp];
    assign acc_wr    = psel && penable && pwrite;

    always_comb begin
        for (int i = 0; i < `SPFC_NCH; i++) begin
            pulse_out[i] = s.ch[i].pulse;
        end
    end

    always_comb begin
        spfc_pkg::spfc_chan_s   c;
        logic [1:0]             chs;
        logic [1:0]             rs;
        logic [1:0]             pidx;
        logic                   chit;
        logic                   ghit;
        logic                   sv;
        logic [`SPFC_CNT_W-1:0] rd;
        c     = '0;
        chs   = paddr[`SPFC_CH_HI:`SPFC_CH_LO];
        rs    = paddr[`SPFC_REG_HI:`SPFC_REG_LO];
        chit  = (paddr[`SPFC_SPACE_HI:`SPFC_SPACE_LO] == `SPFC_CHAN_SPACE);
        ghit  = (paddr == `SPFC_GLOB_ADDR);
        pidx  = '0;
        sv    = 1'b0;
        rd    = '0;
        found = 1'b0;
        wr    = 1'b0;
        geff  = '0;
        ge    = '0;
        se    = '0;
        ke    = '0;
        n     = s;
        pslverr = psel && penable && !chit && !ghit;
        // register read, captured in the setup cycle
        if (ghit) begin
            rd[`SPFC_GL_DROP] = s.drop;
            rd[`SPFC_GL_LVL_LO +: `SPFC_LVL_W] = s.lvl;
        end else if (chit) begin
            unique case (rs)
                `SPFC_REG_CTRL: rd[`SPFC_CTRL_W-1:0] = s.ch[chs].ctrl;
                `SPFC_REG_STAT: begin
                    rd[`SPFC_ST_ARMED] = s.ch[chs].armed;
                    rd[`SPFC_ST_DONE]  = s.ch[chs].done;
                    rd[`SPFC_ST_OVF]   = s.ch[chs].ovf;
                    rd[`SPFC_ST_ORUN]  = s.ch[chs].orun;
                end
                `SPFC_REG_DIV: rd = s.ch[chs].div;
                `SPFC_REG_CNT: rd = s.ch[chs].cnt;
            endcase
        end
        if (psel && !penable)
            n.prdata = rd;
        // register write; clears come first so hardware sets below win
        if (acc_wr && ghit && pwdata[`SPFC_GL_DROP])
            n.drop = 1'b0;
        if (acc_wr && chit) begin
            unique case (rs)
                `SPFC_REG_CTRL: begin
                    n.ch[chs].ctrl = spfc_pkg::spfc_ctrl_s'(pwdata[`SPFC_CTRL_W-1:0]);
                    if (n.ch[chs].ctrl.mode == spfc_pkg::SPFC_OFF)
                        n.ch[chs].armed = 1'b0;
                    if (pwdata[`SPFC_ARM_BIT]) begin
                        n.ch[chs].armed   = (n.ch[chs].ctrl.mode != spfc_pkg::SPFC_OFF);
                        n.ch[chs].done    = 1'b0;
                        n.ch[chs].started = 1'b0;
                        n.ch[chs].pulse   = 1'b0;
                        n.ch[chs].per_ok  = 1'b0;
                        n.ch[chs].cnt     = '0;
                        n.ch[chs].aux     = '0;
                    end
                end
                `SPFC_REG_STAT: begin
                    if (pwdata[`SPFC_ST_OVF])
                        n.ch[chs].ovf = 1'b0;
                    if (pwdata[`SPFC_ST_ORUN])
                        n.ch[chs].orun = 1'b0;
                end
                `SPFC_REG_DIV: n.ch[chs].div = pwdata;
                `SPFC_REG_CNT: ;
            endcase
        end
        // lowest channel with a pending result feeds the FIFO
        for (int i = `SPFC_NCH - 1; i >= 0; i--) begin
            if (s.ch[i].pend_n != `SPFC_PEND_NONE) begin
                found = 1'b1;
                pidx  = 2'(i);
            end
        end
        wr = found && (s.lvl != `SPFC_LVL_W'(`SPFC_FDEPTH));
        if (found) begin
            n.ch[pidx].pend_a = s.ch[pidx].pend_b;
            n.ch[pidx].pend_n = s.ch[pidx].pend_n - `SPFC_PEND_ONE;
        end
        if (found && !wr)
            n.drop = 1'b1;
        if (wr) begin
            n.mem[s.wp].chan = pidx;
            n.mem[s.wp].data = s.ch[pidx].pend_a;
            n.wp = s.wp + `SPFC_PTR_W'(1);
        end
        if (res_valid && res_ready)
            n.rp = s.rp + `SPFC_PTR_W'(1);
        n.lvl = s.lvl + `SPFC_LVL_W'(wr) - `SPFC_LVL_W'(res_valid && res_ready);
        // counter units
        for (int i = 0; i < `SPFC_NCH; i++) begin
            c = n.ch[i];
            unique case (c.ctrl.gsel)
                spfc_pkg::SPFC_G_PARTNER: geff[i] = s.ch[i ^ 1].pulse;
                spfc_pkg::SPFC_G_PFI:     geff[i] = programmable_function_pin;
                default:                  geff[i] = gate_in[i];
            endcase
            if (c.ctrl.src_sel == `SPFC_SRC_PIN)
                sv = source_in[i];
            else
                sv = timebase_in[c.ctrl.src_sel - 2'h1];
            ge[i] = c.armed && (geff[i] != c.gprev);
            se[i] = c.armed && (sv != c.sprev) && (sv != c.ctrl.src_fall);
            ke[i] = c.armed && sample_clk && !c.kprev;
            unique case (c.ctrl.mode)
                spfc_pkg::SPFC_SEMI_SINGLE: begin
                    if (c.started && se[i])
                        c = spfc_inc(c);
                    if (ge[i] && !c.started && geff[i] == c.ctrl.first_hi) begin
                        c.started = 1'b1;
                        c.cnt     = '0;
                    end else if (ge[i] && c.started) begin
                        c       = spfc_put(c, c.cnt);
                        c.done  = 1'b1;
                        c.armed = 1'b0;
                    end
                end
                spfc_pkg::SPFC_SEMI_BUF: begin
                    if (se[i])
                        c = spfc_inc(c);
                    if (ge[i]) begin
                        if (c.started)
                            c = spfc_put(c, c.cnt);
                        else if (geff[i] == c.ctrl.first_hi)
                            c.started = 1'b1;
                        c.cnt = '0;
                    end
                end
                spfc_pkg::SPFC_PERIOD: begin
                    if (c.started && se[i])
                        c = spfc_inc(c);
                    if (ge[i] && geff[i] && !c.started) begin
                        c.started = 1'b1;
                        c.cnt     = '0;
                    end else if (ge[i] && geff[i]) begin
                        c       = spfc_put(c, c.cnt);
                        c.done  = 1'b1;
                        c.armed = 1'b0;
                    end
                end
                spfc_pkg::SPFC_PULSE_GEN: begin
                    if (se[i] && !c.pulse) begin
                        c.pulse = 1'b1;
                        c.cnt   = '0;
                    end else if (se[i]) begin
                        c = spfc_inc(c);
                        if (c.cnt == c.div) begin
                            c.pulse = 1'b0;
                            c.done  = 1'b1;
                            c.armed = 1'b0;
                        end
                    end
                end
                spfc_pkg::SPFC_FREQ_SMP: begin
                    if (se[i])
                        c = spfc_inc(c);
                    if (c.ctrl.avg_en) begin
                        if (ge[i] && geff[i])
                            c.aux = c.aux + `SPFC_CNT_W'(1);
                        if (ke[i]) begin
                            if (c.aux == '0)
                                c.orun = 1'b1;
                            c     = spfc_put(c, c.aux);
                            c     = spfc_put(c, c.cnt);
                            c.aux = '0;
                            c.cnt = '0;
                        end
                    end else begin
                        if (ge[i] && geff[i]) begin
                            if (c.started) begin
                                c.last   = c.cnt;
                                c.per_ok = 1'b1;
                            end
                            c.started = 1'b1;
                            c.cnt     = '0;
                        end
                        if (ke[i]) begin
                            if (c.per_ok)
                                c = spfc_put(c, c.last);
                            else
                                c.orun = 1'b1;
                            c.per_ok = 1'b0;
                        end
                    end
                end
                default: c.armed = 1'b0;
            endcase
            c.gprev = geff[i];
            c.sprev = sv;
            c.kprev = sample_clk;
            n.ch[i] = c;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            for (int i = 0; i < `SPFC_NCH; i++) begin
                s.ch[i].ctrl.avg_en <= `SPFC_AVG_RST;
            end
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence single_end_s;
        s.ch[0].ctrl.mode == spfc_pkg::SPFC_SEMI_SINGLE && s.ch[0].started && ge[0]
            && !acc_wr;
    endsequence
    sequence sample_avg_s;
        s.ch[0].ctrl.mode == spfc_pkg::SPFC_FREQ_SMP && s.ch[0].ctrl.avg_en && ke[0]
            && s.ch[0].pend_n == `SPFC_PEND_NONE && !acc_wr;
    endsequence
    sequence sample_single_s;
        s.ch[0].ctrl.mode == spfc_pkg::SPFC_FREQ_SMP && !s.ch[0].ctrl.avg_en && ke[0]
            && !acc_wr;
    endsequence

    avg_reset_on_a: assert property (!$past(presetn) |-> s.ch[0].ctrl.avg_en)
        else $error("averaging not enabled after reset");
    single_stops_a: assert property (single_end_s |=> (s.ch[0].done && !s.ch[0].armed)
        ##1 ($stable(s.ch[0].cnt) || $past(acc_wr)))
        else $error("single capture did not stop at gate end");
    single_frozen_a: assert property (s.ch[0].done && !acc_wr
        && s.ch[0].ctrl.mode == spfc_pkg::SPFC_SEMI_SINGLE |=> $stable(s.ch[0].cnt))
        else $error("count moved after single capture");
    buf_push_a: assert property (s.ch[0].ctrl.mode == spfc_pkg::SPFC_SEMI_BUF
        && s.ch[0].started && ge[0] && s.ch[0].pend_n == `SPFC_PEND_NONE && !acc_wr
        |=> s.ch[0].pend_n == `SPFC_PEND_ONE)
        else $error("gate edge did not store count");
    buf_first_a: assert property (s.ch[0].ctrl.mode == spfc_pkg::SPFC_SEMI_BUF
        && !s.ch[0].started && ge[0] && geff[0] != s.ch[0].ctrl.first_hi
        && s.ch[0].pend_n == `SPFC_PEND_NONE && !acc_wr
        |=> !s.ch[0].started && s.ch[0].pend_n == `SPFC_PEND_NONE)
        else $error("wrong polarity interval reported first");
    sample_ignored_a: assert property (s.ch[0].ctrl.mode == spfc_pkg::SPFC_SEMI_BUF
        && ke[0] && !ge[0] |=> s.ch[0].pend_n <= $past(s.ch[0].pend_n))
        else $error("sample clock stored a semi-period");
    partner_gate_a: assert property (s.ch[1].ctrl.gsel == spfc_pkg::SPFC_G_PARTNER
        |-> geff[1] == s.ch[0].pulse)
        else $error("partner pulse not on gate");
    pulse_len_a: assert property (s.ch[0].pulse |-> s.ch[0].cnt < s.ch[0].div
        || s.ch[0].div == '0)
        else $error("pulse longer than programmed periods");
    avg_report_a: assert property (sample_avg_s |=> s.ch[0].pend_n == `SPFC_PEND_TWO)
        else $error("averaged sample did not report both totals");
    overrun_set_a: assert property (sample_single_s and !s.ch[0].per_ok
        |=> s.ch[0].orun ##1 (s.ch[0].orun || $past(acc_wr)))
        else $error("missing period did not flag overrun");
    period_report_a: assert property (sample_single_s and s.ch[0].per_ok
        and s.ch[0].pend_n == `SPFC_PEND_NONE |=> s.ch[0].pend_a == $past(s.ch[0].last))
        else $error("single period not reported");
    wrap_flag_a: assert property (se[0] && &s.ch[0].cnt
        && s.ch[0].ctrl.mode == spfc_pkg::SPFC_SEMI_BUF && !acc_wr |=> s.ch[0].ovf)
        else $error("counter wrap not flagged");
    fifo_drop_a: assert property (found && s.lvl == `SPFC_LVL_W'(`SPFC_FDEPTH)
        |=> s.drop && $stable(s.wp))
        else $error("full FIFO did not drop");
endmodule : spfc_core

// File: rtl/spfc_defines.svh
/*
 constants of the semi-period and frequency counter block.
 assumes inclusion by the package and the core only.
*/
`ifndef SPFC_DEFINES_SVH
`define SPFC_DEFINES_SVH
`define SPFC_NCH        4
`define SPFC_CNT_W      32
`define SPFC_FDEPTH     8
`define SPFC_PTR_W      3
`define SPFC_LVL_W      4
`define SPFC_TB_N       3
`define SPFC_ADDR_W     8
`define SPFC_CTRL_W     10
`define SPFC_ARM_BIT    16
`define SPFC_SPACE_HI   7
`define SPFC_SPACE_LO   6
`define SPFC_CH_HI      5
`define SPFC_CH_LO      4
`define SPFC_REG_HI     3
`define SPFC_REG_LO     2
`define SPFC_CHAN_SPACE 2'h0
`define SPFC_GLOB_ADDR  8'h40
`define SPFC_REG_CTRL   2'h0
`define SPFC_REG_STAT   2'h1
`define SPFC_REG_DIV    2'h2
`define SPFC_REG_CNT    2'h3
`define SPFC_ST_ARMED   0
`define SPFC_ST_DONE    1
`define SPFC_ST_OVF     2
`define SPFC_ST_ORUN    3
`define SPFC_GL_DROP    0
`define SPFC_GL_LVL_LO  4
`define SPFC_AVG_RST    1'b1
`define SPFC_SRC_PIN    2'h0
`define SPFC_PEND_NONE  2'h0
`define SPFC_PEND_ONE   2'h1
`define SPFC_PEND_TWO   2'h2
`endif

// File: rtl/spfc_pkg.sv
/*
 types of the semi-period and frequency counter block.
 assumes spfc_defines.svh on the include path.
*/
`include "spfc_defines.svh"
package spfc_pkg;
    typedef enum logic [2:0] {SPFC_OFF, SPFC_SEMI_SINGLE, SPFC_SEMI_BUF, SPFC_PERIOD,
                              SPFC_PULSE_GEN, SPFC_FREQ_SMP} spfc_mode_e;
    typedef enum logic [1:0] {SPFC_G_PIN, SPFC_G_PARTNER, SPFC_G_PFI,
                              SPFC_G_RSVD} spfc_gsel_e;
    typedef struct packed {
        logic       avg_en;
        logic       first_hi;
        spfc_gsel_e gsel;
        logic       src_fall;
        logic [1:0] src_sel;
        spfc_mode_e mode;
    } spfc_ctrl_s;
    typedef struct packed {
        spfc_ctrl_s                ctrl;
        logic                      armed, done, started, pulse, per_ok;
        logic                      ovf, orun, gprev, sprev, kprev;
        logic [1:0]                pend_n;
        logic [`SPFC_CNT_W-1:0]    cnt, aux, div, last, pend_a, pend_b;
    } spfc_chan_s;
    typedef struct packed {
        logic [1:0]             chan;
        logic [`SPFC_CNT_W-1:0] data;
    } spfc_ent_s;
    typedef struct packed {
        spfc_chan_s [`SPFC_NCH-1:0]   ch;
        spfc_ent_s [`SPFC_FDEPTH-1:0] mem;
        logic [`SPFC_PTR_W-1:0]       wp, rp;
        logic [`SPFC_LVL_W-1:0]       lvl;
        logic                         drop;
        logic [`SPFC_CNT_W-1:0]       prdata;
    } spfc_state_s;
endpackage : spfc_pkg

// File: sim/spfc_sig_model.sv
/*
 far side of the counter block: gate, source, timebase and sample clock
 drivers, and a stream sink that stalls at random and collects entries.
 assumes a free-running pclk and inputs sampled on its rising edge.
*/
`timescale 1ns/1ps
module spfc_sig_model (
    input  wire logic                 pclk,
    output logic [3:0]                gate_in,
    output logic [3:0]                source_in,
    output logic [2:0]                timebase_in,
    output logic                      sample_clk,
    output logic                      res_ready,
    input  wire logic                 res_valid,
    input  wire spfc_pkg::spfc_ent_s  res_data
);
    logic                src;
    logic [2:0]          tb_on;
    logic                stall;
    spfc_pkg::spfc_ent_s q[$];
    assign source_in   = {4{src}};
    assign timebase_in = tb_on & {3{src}};
    initial begin
        gate_in    = 4'h0;
        src        = 1'b0;
        tb_on      = 3'h0;
        stall      = 1'b0;
        sample_clk = 1'b0;
        res_ready  = 1'b0;
    end
    // sink takes an entry only on valid and ready, stalls at random
    // entry taken where settled, before the edge that pops it
    always @(negedge pclk) begin
        if (res_valid && res_ready)
            q.push_back(res_data);
    end
    always @(posedge pclk) begin
        res_ready <= !stall && ($urandom % 4 != 0);
    end
    // gate held at one level across n full source pulses
    task automatic run(input logic g, input logic [31:0] n);
        @(posedge pclk);
        gate_in <= {4{g}};
        repeat (2) @(posedge pclk);
        repeat (n) begin
            src <= 1'b1;
            @(posedge pclk);
            src <= 1'b0;
            @(posedge pclk);
        end
    endtask : run
    task automatic sample();
        @(posedge pclk);
        sample_clk <= 1'b1;
        repeat (2) @(posedge pclk);
        sample_clk <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : sample
endmodule : spfc_sig_model

// File: sim/tb_semi_period_frequency_counter.sv
/*
 self-checking bench of the counter block: apb master, far-side model.
 assumes spfc_pkg compiled first and spfc_defines.svh on the include path.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module tb_semi_period_frequency_counter;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd, a, b, c;
    logic [31:0]         e[3];
    logic [3:0]          gate_in, source_in, pulse_out;
    logic [2:0]          timebase_in;
    logic                sample_clk, res_valid, res_ready;
    spfc_pkg::spfc_ent_s res_data;
    int                  error_cnt, n_tests;
    spfc_core dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .gate_in(gate_in), .source_in(source_in),
        .timebase_in(timebase_in), .sample_clk(sample_clk),
        .programmable_function_pin(1'b0), .pulse_out(pulse_out),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
    spfc_sig_model model (.pclk(pclk), .gate_in(gate_in), .source_in(source_in),
        .timebase_in(timebase_in), .sample_clk(sample_clk), .res_ready(res_ready),
        .res_valid(res_valid), .res_data(res_data));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic end_sim();
        if (error_cnt == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= ad;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            error_cnt++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic drain();
        int k;
        k = 0;
        repeat (4) @(posedge pclk);
        while (res_valid !== 1'b0 && k < 200) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 200) begin
            error_cnt++;
            end_sim();
        end
    endtask : drain
    function automatic logic [31:0] ctrl(input logic [2:0] m, input logic [1:0] s,
                                         input logic fh);
        ctrl = 32'h0001_0200 | {23'h0, fh, 2'h0, 1'b0, s, m};
    endfunction : ctrl
    function automatic logic [31:0] rnd();
        rnd = 32'(1 + $urandom % 6);
    endfunction : rnd
    initial begin
        repeat (100000) @(posedge pclk);
        error_cnt++;
        end_sim();
    end
    initial begin
        void'($urandom(32'hd72d));
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(i * 16), 32'h0);
            `CHK(rd, 32'h0000_0200)
        end
        for (int w = 0; w < 2; w++) begin
            apb(w[0], 8'h44, 32'hFFFF_FFFF);
            `CHK({er, rd}, {1'b1, 32'h0})
        end
        // single capture: one count, later gate pulses ignored
        apb(1'b1, 8'h00, ctrl(3'h1, 2'h0, 1'b1));
        a = rnd();
        model.run(1'b0, 32'h2);
        model.run(1'b1, a);
        model.run(1'b0, 32'h2);
        model.run(1'b1, 32'h3);
        model.run(1'b0, 32'h2);
        drain();
        `CHK(model.q.size(), 1)
        `CHK(model.q[0], {2'h0, a})
        apb(1'b0, 8'h04, 32'h0);
        `CHK(rd[1], 1'b1)
        model.q.delete();
        // buffered semi-period, both first-interval polarities
        for (int fh = 1; fh >= 0; fh--) begin
            apb(1'b1, 8'h10, ctrl(3'h2, 2'h0, fh[0]));
            e = '{rnd(), rnd(), rnd()};
            model.run(1'b1, e[0]);
            model.run(1'b0, e[1]);
            model.run(1'b1, e[2]);
            model.run(1'b0, 32'h1);
            apb(1'b1, 8'h10, 32'h0);
            drain();
            `CHK(model.q.size(), fh + 2)
            for (int j = 0; j < model.q.size(); j++)
                `CHK(model.q[j], {2'h1, e[j + 1 - fh]})
            model.q.delete();
        end
        // one-counter period with each source selection
        for (int k = 0; k < 4; k++) begin
            model.tb_on <= (k == 0) ? 3'h0 : 3'(1 << (k - 1));
            apb(1'b1, 8'h20, ctrl(3'h3, k[1:0], 1'b1));
            a = rnd();
            b = rnd();
            model.run(1'b1, a);
            model.run(1'b0, b);
            model.run(1'b1, 32'h2);
            model.run(1'b0, 32'h1);
            drain();
            `CHK(model.q.size(), 1)
            `CHK(model.q[0], {2'h2, a + b})
            model.q.delete();
        end
        model.tb_on <= 3'h0;
        // sample-clocked averaged frequency and overrun
        apb(1'b1, 8'h30, ctrl(3'h5, 2'h0, 1'b1));
        model.sample();
        apb(1'b1, 8'h34, 32'h0000_0008);
        drain();
        model.q.delete();
        a = rnd();
        b = rnd();
        model.run(1'b1, a);
        model.run(1'b0, b);
        model.sample();
        apb(1'b0, 8'h34, 32'h0);
        `CHK(rd[3], 1'b0)
        model.sample();
        apb(1'b0, 8'h34, 32'h0);
        `CHK(rd[3], 1'b1)
        apb(1'b1, 8'h30, 32'h0);
        drain();
        `CHK(model.q.size(), 4)
        `CHK({model.q[0], model.q[1]}, {2'h3, 32'h1, 2'h3, a + b})
        model.q.delete();
        // partner pulse of N source periods gates counter one
        b = rnd();
        apb(1'b1, 8'h08, b);
        apb(1'b1, 8'h10, ctrl(3'h1, 2'h0, 1'b1) | 32'h40);
        apb(1'b1, 8'h00, ctrl(3'h4, 2'h0, 1'b1));
        model.run(1'b0, b + 32'h2);
        drain();
        `CHK(model.q.size(), 1)
        `CHK(model.q[0], {2'h1, b})
        `CHK(pulse_out, 4'h0)
        model.q.delete();
        // full FIFO with a stalled sink
        model.stall <= 1'b1;
        apb(1'b1, 8'h10, ctrl(3'h2, 2'h0, 1'b1));
        for (int j = 0; j < 13; j++)
            model.run(~j[0], 32'h1);
        apb(1'b1, 8'h10, 32'h0);
        repeat (4) @(posedge pclk);
        apb(1'b0, 8'h40, 32'h0);
        `CHK({rd[7:4], rd[0]}, {4'h8, 1'b1})
        apb(1'b1, 8'h40, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        `CHK(rd[0], 1'b0)
        model.stall <= 1'b0;
        drain();
        apb(1'b0, 8'h40, 32'h0);
        `CHK(rd[7:4], 4'h0)
        `CHK(model.q[0], {2'h1, 32'h1})
        end_sim();
    end
endmodule : tb_semi_period_frequency_counter
